// [shared/core_regs_defs.svh]
// Constants for the core register set: status word layout, vector table and register indices.
// Assumes inclusion by bare name from design and bench files.
`ifndef CORE_REGS_DEFS_SVH
`define CORE_REGS_DEFS_SVH
`define SW_CARRY_BIT 0
`define SW_ZERO_BIT 1
`define SW_NEG_BIT 2
`define SW_IRQ_EN_BIT 3
`define SW_HALT_BIT 4
`define SW_XTAL_STOP_BIT 5
`define SW_CLKGEN0_BIT 6
`define SW_CLKGEN1_BIT 7
`define SW_OVFL_BIT 8
`define SW_RESET_VAL 16'h0000
`define SW_USED_MASK 16'h01FF
`define VECTOR_TOP_ADDR 20'h0FFFE
`define RESET_VECTOR_IDX 5'h00
`define REG_PC 4'h0
`define REG_SP 4'h1
`define REG_SW 4'h2
`define REG_CG 4'h3
`endif

// [shared/core_regs_pkg.sv]
// Types shared by the core register set and its bench.
// Assumes the constants header is compiled alongside.
`default_nettype none
package core_regs_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_WRITE = 4'b0001,
        OP_ADVANCE = 4'b0010,
        OP_NEAR_JUMP = 4'b0011,
        OP_FAR_JUMP = 4'b0100,
        OP_NEAR_CALL = 4'b0101,
        OP_FAR_CALL = 4'b0110,
        OP_NEAR_EXIT = 4'b0111,
        OP_FAR_EXIT = 4'b1000,
        OP_IRQ = 4'b1001,
        OP_IRQ_RETURN = 4'b1010,
        OP_PUSH = 4'b1011,
        OP_POP = 4'b1100
    } core_op_type;
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_ADDR = 2'b10
    } op_size_type;
    typedef enum logic [1:0] {
        ALU_NONE = 2'b00,
        ALU_ADD = 2'b01,
        ALU_SUB = 2'b10,
        ALU_LOGIC = 2'b11
    } alu_kind_type;
endpackage : core_regs_pkg
`default_nettype wire

// [hw/flag_calc.sv]
// Computes arithmetic status flags for one operation result.
// Assumes operand and result come from the same cycle on the core clock.
`timescale 1ns/1ns
`default_nettype none
module flag_calc
    import core_regs_pkg::*;
(
    input wire alu_kind_type kind_in,
    input wire op_size_type size_in,
    input wire logic [19:0] src_in,
    input wire logic [19:0] dst_in,
    input wire logic [19:0] res_in,
    input wire logic carry_in,
    output logic carry_out,
    output logic zero_out,
    output logic neg_out,
    output logic ovfl_out
);
    wire [4:0] msb = (size_in == SIZE_BYTE) ? 5'd7 : (size_in == SIZE_WORD) ? 5'd15 : 5'd19;
    wire [19:0] mask = (size_in == SIZE_BYTE) ? 20'h000FF :
                       (size_in == SIZE_WORD) ? 20'h0FFFF : 20'hFFFFF;
    wire s_src = src_in[msb];
    wire s_dst = dst_in[msb];
    wire s_res = res_in[msb];
    assign zero_out = ((res_in & mask) == 20'h00000);
    assign neg_out = s_res;
    assign carry_out = carry_in;
    assign ovfl_out = (kind_in == ALU_ADD) ? ((s_src == s_dst) && (s_res != s_dst)) :
                      (kind_in == ALU_SUB) ? ((s_src != s_dst) && (s_res != s_dst)) :
                      1'b0;
endmodule : flag_calc
`default_nettype wire

// [hw/cpu_core_register_set.sv]
// Core register file: instruction pointer, stack pointer, status word and
// working registers, with call, return, interrupt and stack sequencing.
// Assumes a decoder drives one operation per cycle and a memory that
// answers reads in the same cycle on mem_rdata_in.
`timescale 1ns/1ns
`default_nettype none
`include "core_regs_defs.svh"
module cpu_core_register_set
    import core_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Operation request
    input wire logic op_valid_in,
    input wire core_op_type op_in,
    input wire op_size_type size_in,
    input wire logic [3:0] dst_reg_in,
    input wire logic [19:0] op_data_in,
    input wire logic sign_extend_op_in,
    input wire logic [2:0] instr_len_in,
    input wire logic [4:0] irq_vector_idx_in,
    input wire logic irq_nonmaskable_in,
    // Arithmetic result for flags
    input wire alu_kind_type alu_kind_in,
    input wire logic [19:0] alu_src_in,
    input wire logic [19:0] alu_dst_in,
    input wire logic alu_carry_in,
    // Memory bus
    input wire logic [15:0] mem_rdata_in,
    output logic [19:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    output logic mem_wr_out,
    output logic mem_rd_out,
    // Register file read port
    input wire logic [3:0] rd_reg_in,
    output logic [19:0] rd_data_out,
    // Status
    output logic op_ready_out,
    output logic [19:0] instr_pointer_out,
    output logic [19:0] stack_top_ptr_out,
    output logic [15:0] core_status_word_out,
    output logic irq_accept_out,
    output logic core_halt_out,
    output logic xtal_stop_out,
    output logic [1:0] clkgen_ctl_out
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH_LO = 3'b001,
        ST_PUSH_HI = 3'b010,
        ST_VECTOR = 3'b011,
        ST_POP_HI = 3'b100,
        ST_POP_LO = 3'b101
    } seq_state_type;

    logic [19:0] gpr_q [4:15];
    logic [19:0] ip_q, ip_d;
    logic [19:0] sp_q, sp_d;
    logic [15:0] sw_q, sw_d;
    seq_state_type st_q, st_d;
    core_op_type cur_op_q, cur_op_d;
    logic [19:0] ret_q, ret_d;
    logic [15:0] pop_lo_q, pop_lo_d;
    logic [4:0] vec_q, vec_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic wr_q, wr_d, rd_q, rd_d;
    logic [19:0] rd_data_q;
    logic accept_q;

    wire fl_c, fl_z, fl_n, fl_v;
    flag_calc u_flags (
        .kind_in(alu_kind_in),
        .size_in(size_in),
        .src_in(alu_src_in),
        .dst_in(alu_dst_in),
        .res_in(op_data_in),
        .carry_in(alu_carry_in),
        .carry_out(fl_c),
        .zero_out(fl_z),
        .neg_out(fl_n),
        .ovfl_out(fl_v)
    );

    wire idle = (st_q == ST_IDLE);
    wire go = op_valid_in && idle;
    // Sized write value: byte clears 19:8 or sign extends, word clears 19:16.
    wire [19:0] sized_val = (size_in == SIZE_BYTE) ?
        (sign_extend_op_in ? {{12{op_data_in[7]}}, op_data_in[7:0]}
                           : {12'h000, op_data_in[7:0]}) :
        (size_in == SIZE_WORD) ? {4'h0, op_data_in[15:0]} : op_data_in;
    wire irq_ok = irq_nonmaskable_in || sw_q[`SW_IRQ_EN_BIT];
    wire [19:0] vec_addr = `VECTOR_TOP_ADDR - {14'h0000, vec_q, 1'b0};
    wire [19:0] sp_dec = {sp_q[19:1] - 19'd1, 1'b0};
    wire [19:0] sp_inc = {sp_q[19:1] + 19'd1, 1'b0};
    // A length code of zero stands for an eight-byte instruction, four words.
    wire [2:0] step_words = (instr_len_in[2:1] == 2'h0) ? 3'h4 : {1'b0, instr_len_in[2:1]};
    wire [19:0] ip_step = {ip_q[19:1] + {16'h0000, step_words}, 1'b0};
    wire sw_flag_write = go && (alu_kind_in != ALU_NONE) &&
                         !(op_in == OP_WRITE && dst_reg_in == `REG_SW);
    wire sw_reg_write = go && op_in == OP_WRITE && dst_reg_in == `REG_SW &&
                        size_in == SIZE_WORD;

    always_comb begin
        ip_d = ip_q;
        sp_d = sp_q;
        sw_d = sw_q;
        st_d = st_q;
        cur_op_d = cur_op_q;
        ret_d = ret_q;
        pop_lo_d = pop_lo_q;
        vec_d = vec_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        if (sw_flag_write) begin
            sw_d[`SW_CARRY_BIT] = fl_c;
            sw_d[`SW_ZERO_BIT] = fl_z;
            sw_d[`SW_NEG_BIT] = fl_n;
            sw_d[`SW_OVFL_BIT] = fl_v;
        end
        if (sw_reg_write) begin
            sw_d = op_data_in[15:0] & `SW_USED_MASK;
        end
        unique case (st_q)
            ST_IDLE: begin
                if (go) begin
                    cur_op_d = op_in;
                    unique case (op_in)
                        OP_ADVANCE: ip_d = ip_step;
                        OP_NEAR_JUMP: ip_d = {4'h0, op_data_in[15:1], 1'b0};
                        OP_FAR_JUMP: ip_d = {op_data_in[19:1], 1'b0};
                        OP_WRITE: begin
                            if (dst_reg_in == `REG_PC) begin
                                ip_d = {sized_val[19:1], 1'b0};
                            end else if (dst_reg_in == `REG_SP) begin
                                sp_d = {sized_val[19:1], 1'b0};
                            end
                        end
                        OP_NEAR_CALL, OP_FAR_CALL, OP_IRQ, OP_PUSH: begin
                            if (op_in != OP_IRQ || irq_ok) begin
                                ret_d = (op_in == OP_PUSH) ? sized_val : ip_q;
                                vec_d = irq_vector_idx_in;
                                if (op_in == OP_NEAR_CALL) begin
                                    ip_d = {4'h0, op_data_in[15:1], 1'b0};
                                end else if (op_in == OP_FAR_CALL) begin
                                    ip_d = {op_data_in[19:1], 1'b0};
                                end
                                sp_d = sp_dec;
                                addr_d = sp_dec;
                                wr_d = 1'b1;
                                if (op_in == OP_NEAR_CALL ||
                                    (op_in == OP_PUSH && size_in != SIZE_ADDR)) begin
                                    wdata_d = (op_in == OP_PUSH) ? sized_val[15:0]
                                                                 : ip_q[15:0];
                                    st_d = ST_IDLE;
                                end else begin
                                    // Far calls and pushes keep the high part above the low word; interrupts put the low pointer word above.
                                    wdata_d = (op_in == OP_IRQ) ? ip_q[15:0] : {12'h000,
                                              ((op_in == OP_PUSH) ? sized_val[19:16]
                                                                  : ip_q[19:16])};
                                    st_d = ST_PUSH_HI;
                                end
                            end
                        end
                        OP_NEAR_EXIT, OP_FAR_EXIT, OP_IRQ_RETURN, OP_POP: begin
                            addr_d = sp_q;
                            rd_d = 1'b1;
                            st_d = ST_POP_LO;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_PUSH_HI: begin
                sp_d = sp_dec;
                addr_d = sp_dec;
                wr_d = 1'b1;
                if (cur_op_q == OP_IRQ) begin
                    wdata_d = {ip_q[19:16], sw_q[11:0]};
                    sw_d[`SW_IRQ_EN_BIT] = 1'b0;
                    sw_d[`SW_HALT_BIT] = 1'b0;
                    st_d = ST_VECTOR;
                end else begin
                    wdata_d = ret_q[15:0];
                    st_d = ST_IDLE;
                end
            end
            ST_VECTOR: begin
                addr_d = vec_addr;
                rd_d = 1'b1;
                st_d = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                ip_d = {4'h0, mem_rdata_in[15:1], 1'b0};
                st_d = ST_IDLE;
            end
            ST_POP_LO: begin
                pop_lo_d = mem_rdata_in;
                if (cur_op_q == OP_NEAR_EXIT) begin
                    ip_d = {4'h0, mem_rdata_in[15:1], 1'b0};
                    sp_d = sp_q + 20'h00002;
                    st_d = ST_IDLE;
                end else if (cur_op_q == OP_POP && size_in != SIZE_ADDR) begin
                    sp_d = (dst_reg_in == `REG_SP) ? {4'h0, mem_rdata_in[15:1], 1'b0}
                                                  : sp_q + 20'h00002;
                    st_d = ST_IDLE;
                end else begin
                    addr_d = sp_q + 20'h00002;
                    rd_d = 1'b1;
                    st_d = ST_POP_HI;
                end
            end
            ST_POP_HI: begin
                st_d = ST_IDLE;
                if (cur_op_q == OP_IRQ_RETURN) begin
                    sw_d = pop_lo_q & `SW_USED_MASK;
                    ip_d = {pop_lo_q[15:12], mem_rdata_in[15:1], 1'b0};
                    sp_d = sp_q + 20'h00004;
                end else if (cur_op_q == OP_FAR_EXIT) begin
                    ip_d = {mem_rdata_in[3:0], pop_lo_q[15:1], 1'b0};
                    sp_d = sp_q + 20'h00004;
                end else begin
                    sp_d = (dst_reg_in == `REG_SP) ? {mem_rdata_in[3:0], pop_lo_q[15:1], 1'b0}
                                                  : sp_q + 20'h00004;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // Interrupt return pops status first, so the low word read is the status.
    wire pop_gpr = (st_q == ST_POP_LO && cur_op_q == OP_POP && size_in != SIZE_ADDR) ||
                   (st_q == ST_POP_HI && cur_op_q == OP_POP);
    wire [19:0] pop_val = (st_q == ST_POP_HI) ? {mem_rdata_in[3:0], pop_lo_q}
                                              : {4'h0, mem_rdata_in};
    wire gpr_we = go && op_in == OP_WRITE && dst_reg_in >= 4'h4;
    wire [19:0] rd_mux = (rd_reg_in == `REG_PC) ? ip_q :
                         (rd_reg_in == `REG_SP) ? sp_q :
                         (rd_reg_in == `REG_SW) ? {4'h0, sw_q} :
                         (rd_reg_in == `REG_CG) ? 20'h00000 : gpr_q[rd_reg_in];

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ip_q <= 20'h00000;
            sp_q <= 20'h00000;
            sw_q <= `SW_RESET_VAL;
            st_q <= ST_IDLE;
            cur_op_q <= OP_NONE;
            ret_q <= 20'h00000;
            pop_lo_q <= 16'h0000;
            vec_q <= `RESET_VECTOR_IDX;
            addr_q <= 20'h00000;
            wdata_q <= 16'h0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_data_q <= 20'h00000;
            accept_q <= 1'b0;
        end else begin
            ip_q <= ip_d;
            sp_q <= sp_d;
            sw_q <= sw_d;
            st_q <= st_d;
            cur_op_q <= cur_op_d;
            ret_q <= ret_d;
            pop_lo_q <= pop_lo_d;
            vec_q <= vec_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            rd_data_q <= rd_mux;
            accept_q <= go && op_in == OP_IRQ && irq_ok;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (gpr_we) begin
            gpr_q[dst_reg_in] <= sized_val;
        end else if (pop_gpr && dst_reg_in >= 4'h4) begin
            gpr_q[dst_reg_in] <= pop_val;
        end
    end

    assign mem_addr_out = addr_q;
    assign mem_wdata_out = wdata_q;
    assign mem_wr_out = wr_q;
    assign mem_rd_out = rd_q;
    assign rd_data_out = rd_data_q;
    assign op_ready_out = (st_q == ST_IDLE);
    assign instr_pointer_out = ip_q;
    assign stack_top_ptr_out = sp_q;
    assign core_status_word_out = sw_q;
    assign irq_accept_out = accept_q;
    assign core_halt_out = sw_q[`SW_HALT_BIT];
    assign xtal_stop_out = sw_q[`SW_XTAL_STOP_BIT] & sw_q[`SW_HALT_BIT];
    assign clkgen_ctl_out = {sw_q[`SW_CLKGEN1_BIT], sw_q[`SW_CLKGEN0_BIT]};
endmodule : cpu_core_register_set
`default_nettype wire

// [verif/cpu_core_register_set_properties.sv]
// Checker for the core register set, bound to its top module.
// Assumes it sees only the top module's ports, all on core_clk_in.
`timescale 1ns/1ns
`default_nettype none
module core_regs_checker
    import core_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Requests
    input wire logic op_valid_in,
    input wire core_op_type op_in,
    input wire logic [19:0] op_data_in,
    input wire logic [2:0] instr_len_in,
    input wire logic [4:0] irq_vector_idx_in,
    input wire logic irq_nonmaskable_in,
    // Memory bus
    input wire logic [19:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic mem_wr_out,
    input wire logic mem_rd_out,
    // Status
    input wire logic op_ready_out,
    input wire logic [19:0] instr_pointer_out,
    input wire logic [19:0] stack_top_ptr_out,
    input wire logic [15:0] core_status_word_out,
    input wire logic irq_accept_out,
    input wire logic core_halt_out,
    input wire logic xtal_stop_out,
    input wire logic [1:0] clkgen_ctl_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic take;
    logic irq_ok;
    assign take = op_valid_in && op_ready_out;
    assign irq_ok = take && op_in == OP_IRQ && (core_status_word_out[3] || irq_nonmaskable_in);
    a_ptr_even: assert property (instr_pointer_out[0] == 1'h0)
        else $error("instruction pointer odd");
    a_stack_even: assert property (stack_top_ptr_out[0] == 1'h0)
        else $error("stack pointer odd");
    a_reserved_zero: assert property (core_status_word_out[15:9] == 7'h00)
        else $error("reserved status bits set");
    a_halt_follows: assert property (core_halt_out == core_status_word_out[4])
        else $error("halt output differs from status");
    a_xtal_gated: assert property (
        xtal_stop_out == (core_status_word_out[5] && core_status_word_out[4]))
        else $error("crystal stop not gated by halt");
    a_clkgen_bits: assert property (clkgen_ctl_out == core_status_word_out[7:6])
        else $error("clock generator bits misplaced");
    a_reset_clear: assert property (disable iff (1'h0)
        !rst_n_in |=> core_status_word_out == 16'h0000 && instr_pointer_out == 20'h00000)
        else $error("reset did not clear state");
    a_irq_gating: assert property (irq_accept_out |-> $past(irq_ok))
        else $error("interrupt accepted while blocked");
    a_vector_fetch: assert property (
        irq_ok |-> ##3 mem_rd_out && mem_addr_out == 20'h0FFFE
            - {14'h0000, $past(irq_vector_idx_in, 3), 1'h0}
            ##[1:3] instr_pointer_out[19:16] == 4'h0)
        else $error("vector fetch wrong");
    a_near_call: assert property (
        take && op_in == OP_NEAR_CALL |=> mem_wr_out && mem_addr_out ==
            $past(stack_top_ptr_out) - 20'h00002 &&
            {4'h0, mem_wdata_out} == ($past(instr_pointer_out) & 20'h0FFFF))
        else $error("near call push wrong");
    a_near_jump: assert property (
        take && op_in == OP_NEAR_JUMP |=> instr_pointer_out == ($past(op_data_in) & 20'h0FFFE))
        else $error("near jump target wrong");
    a_advance_len: assert property (
        take && op_in == OP_ADVANCE |=> instr_pointer_out == $past(instr_pointer_out)
            + ($past(instr_len_in) == 3'h0 ? 20'h00008 : {17'h00000, $past(instr_len_in)}))
        else $error("pointer advance wrong");
    c_irq_taken: cover property (irq_accept_out);
    c_near_call: cover property (take && op_in == OP_NEAR_CALL);
    c_far_exit: cover property (take && op_in == OP_FAR_EXIT);
endmodule : core_regs_checker
bind cpu_core_register_set core_regs_checker i_checker (.*);
`default_nettype wire

// [verif/prog_data_mem.sv]
// Program and data memory seen by the core, 1K words.
// Assumes reads are answered while the strobe stands and held one cycle more.
`timescale 1ns/1ns
`default_nettype none
module prog_data_mem (
    input wire logic core_clk_in,
    input wire logic [19:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    input wire logic mem_wr_in,
    input wire logic mem_rd_in,
    output logic [15:0] mem_rdata_out
);
    logic [15:0] mem [0:1023];
    logic [9:0] held_idx_q;
    logic held_q = 1'h0;
    logic [15:0] noise_q = 16'hA5C3;
    always @(posedge core_clk_in) begin
        held_q <= mem_rd_in;
        held_idx_q <= mem_addr_in[10:1];
        noise_q <= ~noise_q;
        if (mem_wr_in) begin
            mem[mem_addr_in[10:1]] <= mem_wdata_in;
        end
    end
    // Outside a read and the cycle after it, the bus shows a changing pattern, never stale data.
    always_comb begin
        if (mem_rd_in) begin
            mem_rdata_out = mem[mem_addr_in[10:1]];
        end else if (held_q) begin
            mem_rdata_out = mem[held_idx_q];
        end else begin
            mem_rdata_out = noise_q;
        end
    end
endmodule : prog_data_mem
`default_nettype wire

// [verif/cpu_core_register_set_bench.sv]
// Bench for the core register set: pointer, stack, calls, interrupts, status.
// Assumes the memory model on the bus and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_register_set_bench;
    import core_regs_pkg::*;
    logic core_clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic op_valid_in = 1'h0;
    core_op_type op_in = OP_NONE;
    op_size_type size_in = SIZE_WORD;
    logic [3:0] dst_reg_in = 4'h0;
    logic [19:0] op_data_in = 20'h00000;
    logic sign_extend_op_in = 1'h0;
    logic [2:0] instr_len_in = 3'h2;
    logic [4:0] irq_vector_idx_in = 5'h00;
    logic irq_nonmaskable_in = 1'h0;
    alu_kind_type alu_kind_in = ALU_NONE;
    logic [19:0] alu_src_in = 20'h00000;
    logic [19:0] alu_dst_in = 20'h00000;
    logic alu_carry_in = 1'h0;
    logic [3:0] rd_reg_in = 4'h0;
    logic [15:0] mem_rdata_in;
    logic [19:0] mem_addr_out;
    logic [15:0] mem_wdata_out;
    logic mem_wr_out;
    logic mem_rd_out;
    logic [19:0] rd_data_out;
    logic op_ready_out;
    logic [19:0] instr_pointer_out;
    logic [19:0] stack_top_ptr_out;
    logic [15:0] core_status_word_out;
    logic irq_accept_out;
    logic core_halt_out;
    logic xtal_stop_out;
    logic [1:0] clkgen_ctl_out;
    int errors = 0;
    int check_count = 0;
    int accepts = 0;
    cpu_core_register_set i_dut (.*);
    prog_data_mem i_mem (
        .core_clk_in(core_clk_in),
        .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out),
        .mem_wr_in(mem_wr_out),
        .mem_rd_in(mem_rd_out),
        .mem_rdata_out(mem_rdata_in)
    );
    always #10 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        if (irq_accept_out === 1'h1) begin
            accepts++;
        end
    end
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Entered at a falling edge with the core ready; returns once ready again.
    task automatic run_op(input core_op_type o, input op_size_type s, input logic [3:0] d,
        input logic [19:0] v);
        int n;
        n = 0;
        op_in = o;
        size_in = s;
        dst_reg_in = d;
        op_data_in = v;
        op_valid_in = 1'h1;
        @(negedge core_clk_in);
        op_valid_in = 1'h0;
        alu_kind_in = ALU_NONE;
        sign_extend_op_in = 1'h0;
        repeat (2) @(negedge core_clk_in);
        while (op_ready_out !== 1'h1 && n < 20) begin
            @(negedge core_clk_in);
            n++;
        end
        if (n == 20) begin
            errors++;
            $display("[FAIL] %0t ns operation never completed", $time);
        end
    endtask : run_op
    task automatic rd_chk(input logic [3:0] r, input logic [19:0] e);
        rd_reg_in = r;
        repeat (2) @(negedge core_clk_in);
        chk(rd_data_out, e);
    endtask : rd_chk
    task automatic t_pointer();
        chk({4'h0, core_status_word_out}, 20'h00000);
        run_op(OP_WRITE, SIZE_ADDR, 4'h1, 20'h00400);
        run_op(OP_WRITE, SIZE_WORD, 4'h0, 20'hF1234);
        chk(instr_pointer_out, 20'h01234);
        run_op(OP_WRITE, SIZE_ADDR, 4'h0, 20'hA5437);
        chk(instr_pointer_out, 20'hA5436);
        for (int i = 1; i <= 4; i++) begin
            instr_len_in = 3'(2 * i);
            run_op(OP_ADVANCE, SIZE_WORD, 4'h0, 20'h00000);
        end
        chk(instr_pointer_out, 20'hA544A);
        chk(stack_top_ptr_out, 20'h00400);
    endtask : t_pointer
    task automatic t_calls();
        run_op(OP_NEAR_JUMP, SIZE_WORD, 4'h0, 20'h32468);
        chk(instr_pointer_out, 20'h02468);
        run_op(OP_WRITE, SIZE_ADDR, 4'h0, 20'hA5442);
        run_op(OP_NEAR_CALL, SIZE_WORD, 4'h0, 20'h31110);
        chk(instr_pointer_out, 20'h01110);
        chk({4'h0, i_mem.mem[10'h1FF]}, 20'h05442);
        run_op(OP_NEAR_EXIT, SIZE_WORD, 4'h0, 20'h00000);
        chk(instr_pointer_out, 20'h05442);
        chk(stack_top_ptr_out, 20'h00400);
        run_op(OP_WRITE, SIZE_ADDR, 4'h0, 20'hB8642);
        run_op(OP_FAR_CALL, SIZE_ADDR, 4'h0, 20'hC1110);
        chk(stack_top_ptr_out, 20'h003FC);
        chk({4'h0, i_mem.mem[10'h1FF]}, 20'h0000B);
        chk({4'h0, i_mem.mem[10'h1FE]}, 20'h08642);
        run_op(OP_FAR_EXIT, SIZE_ADDR, 4'h0, 20'h00000);
        chk(instr_pointer_out, 20'hB8642);
        chk(stack_top_ptr_out, 20'h00400);
        run_op(OP_FAR_JUMP, SIZE_ADDR, 4'h0, 20'hD2222);
        chk(instr_pointer_out, 20'hD2222);
    endtask : t_calls
    task automatic t_irq();
        i_mem.mem[10'h3FE] = 16'h4440;
        irq_vector_idx_in = 5'h01;
        run_op(OP_IRQ, SIZE_WORD, 4'h0, 20'h00000);
        chk(20'(accepts), 20'h00000);
        run_op(OP_WRITE, SIZE_WORD, 4'h2, 20'h00008);
        run_op(OP_IRQ, SIZE_WORD, 4'h0, 20'h00000);
        chk(20'(accepts), 20'h00001);
        chk(instr_pointer_out, 20'h04440);
        chk({4'h0, i_mem.mem[10'h1FF]}, 20'h02222);
        chk({4'h0, i_mem.mem[10'h1FE]}, 20'h0D008);
        run_op(OP_IRQ_RETURN, SIZE_WORD, 4'h0, 20'h00000);
        chk(instr_pointer_out, 20'hD2222);
        chk({4'h0, core_status_word_out}, 20'h00008);
        run_op(OP_WRITE, SIZE_WORD, 4'h2, 20'h00000);
        irq_nonmaskable_in = 1'h1;
        run_op(OP_IRQ, SIZE_WORD, 4'h0, 20'h00000);
        irq_nonmaskable_in = 1'h0;
        chk(20'(accepts), 20'h00002);
        run_op(OP_IRQ_RETURN, SIZE_WORD, 4'h0, 20'h00000);
    endtask : t_irq
    task automatic t_flags();
        alu_kind_type kinds [3] = '{ALU_ADD, ALU_SUB, ALU_ADD};
        logic [19:0] dsts [3] = '{20'h01000, 20'h08000, 20'h0FFFF};
        logic [19:0] ress [3] = '{20'h08000, 20'h07FFF, 20'h00000};
        logic [19:0] sws [3] = '{20'h00104, 20'h00101, 20'h00003};
        for (int i = 0; i < 3; i++) begin
            alu_kind_in = kinds[i];
            alu_src_in = (i == 0) ? 20'h07000 : 20'h00001;
            alu_dst_in = dsts[i];
            alu_carry_in = (i != 0);
            run_op(OP_WRITE, SIZE_WORD, 4'h5, ress[i]);
            chk({4'h0, core_status_word_out}, sws[i]);
        end
        run_op(OP_WRITE, SIZE_BYTE, 4'h5, 20'hFFF85);
        rd_chk(4'h5, 20'h00085);
        sign_extend_op_in = 1'h1;
        run_op(OP_WRITE, SIZE_BYTE, 4'h5, 20'h00085);
        rd_chk(4'h5, 20'hFFF85);
        run_op(OP_WRITE, SIZE_WORD, 4'hF, 20'hF1234);
        rd_chk(4'hF, 20'h01234);
        rd_chk(4'h3, 20'h00000);
        run_op(OP_WRITE, SIZE_BYTE, 4'h2, 20'h000FF);
        chk({4'h0, core_status_word_out}, 20'h00003);
        run_op(OP_PUSH, SIZE_WORD, 4'h4, 20'h00600);
        chk(stack_top_ptr_out, 20'h003FE);
        run_op(OP_POP, SIZE_WORD, 4'h1, 20'h00000);
        chk(stack_top_ptr_out, 20'h00600);
    endtask : t_flags
    task automatic t_power();
        run_op(OP_WRITE, SIZE_WORD, 4'h2, 20'h0FFE0);
        chk({4'h0, core_status_word_out}, 20'h001E0);
        chk({17'h00000, xtal_stop_out, core_halt_out, clkgen_ctl_out}, 20'h00003);
        op_data_in = 20'h00030;
        op_valid_in = 1'h1;
        @(negedge core_clk_in);
        op_valid_in = 1'h0;
        repeat (2) @(negedge core_clk_in);
        chk({17'h00000, xtal_stop_out, core_halt_out, clkgen_ctl_out}, 20'h0000C);
        rst_n_in = 1'h0;
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'h1;
        @(negedge core_clk_in);
        chk({4'h0, core_status_word_out}, 20'h00000);
    endtask : t_power
    initial begin
        repeat (16) @(negedge core_clk_in);
        rst_n_in = 1'h1;
        t_pointer();
        t_calls();
        t_irq();
        t_flags();
        t_power();
        results();
    end
    // About 130 cycles of work expected; this allows over twenty times that.
    initial begin
        #60000;
        errors++;
        results();
    end
endmodule : cpu_core_register_set_bench
`default_nettype wire
